//--- core/t16c_pkg.sv
// Constants shared by the 16-bit timer control block and its helpers.
// Assumes an APB slave with one aligned 32-bit word per register.
`default_nettype none
package t16c_pkg;

  // ---------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_CTRL_A    = 6'h00;
  localparam logic [5:0] IDX_CTRL_B    = 6'h01;
  localparam logic [5:0] IDX_CTRL_C    = 6'h02;
  localparam logic [5:0] IDX_CTRL_D    = 6'h03;
  localparam logic [5:0] IDX_E_CLR     = 6'h04;
  localparam logic [5:0] IDX_E_SET     = 6'h05;
  localparam logic [5:0] IDX_F_CLR     = 6'h06;
  localparam logic [5:0] IDX_F_SET     = 6'h07;
  localparam logic [5:0] IDX_BUF_BASE  = 6'h10;
  localparam logic [5:0] IDX_VAL_BASE  = 6'h14;
  localparam logic [5:0] IDX_COUNT     = 6'h18;
  localparam int unsigned ADDR_LSB     = 2;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned ENABLE_BIT = 0;
  localparam int unsigned CLOCK_DIVIDER_SELECT_LSB = 1;
  localparam int unsigned WGM_LSB    = 0;
  localparam int unsigned AUTO_LOCK_UPDATE_BIT  = 3;
  localparam int unsigned OVR_LSB    = 4;
  localparam int unsigned SPLIT_BIT  = 0;
  localparam int unsigned DIR_BIT    = 0;
  localparam int unsigned LOCK_BIT   = 1;
  localparam int unsigned CMD_LSB    = 2;

  // ---------------------------------------------------------------
  // Values after reset
  // ---------------------------------------------------------------
  localparam logic [3:0]  CTRL_A_RESET  = 4'h0;
  localparam logic [6:0]  CTRL_B_RESET  = 7'h00;
  localparam logic [2:0]  CTRL_C_RESET  = 3'h0;
  localparam logic [3:0]  BV_RESET      = 4'h0;
  localparam logic [15:0] PERIOD_RESET  = 16'hFFFF;
  localparam logic [15:0] COMPARE_RESET = 16'h0000;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;

  // ---------------------------------------------------------------
  // Waveform modes and commands
  // ---------------------------------------------------------------
  localparam logic [2:0] WGM_NORMAL       = 3'h0;
  localparam logic [2:0] WGM_FREQ         = 3'h1;
  localparam logic [2:0] WGM_ONE_SLOPE    = 3'h3;
  localparam logic [2:0] WGM_TWO_TOP      = 3'h5;
  localparam logic [2:0] WGM_TWO_BOTH     = 3'h6;
  localparam logic [2:0] WGM_TWO_BOTTOM   = 3'h7;
  localparam logic [1:0] CMD_NONE         = 2'h0;
  localparam logic [1:0] CMD_UPDATE       = 2'h1;
  localparam logic [1:0] CMD_RESTART      = 2'h2;
  localparam logic [1:0] CMD_HARD_RESET   = 2'h3;

  // Prescaler masks: divide by 1, 2, 4, 8, 16, 64, 256, 1024
  localparam logic [9:0] DIV_MASK [8] = '{
    10'h000, 10'h001, 10'h003, 10'h007,
    10'h00F, 10'h03F, 10'h0FF, 10'h3FF
  };
  localparam logic [9:0] DIV_RESET = 10'h000;

endpackage
`default_nettype wire

//--- core/t16c_prescaler.sv
// Prescaler producing the timer count enable from pclk.
// Assumes run and sel come from registers on the same clock.
`default_nettype none
module t16c_prescaler
  import t16c_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);

  logic [9:0] div;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div <= DIV_RESET;
    else if (!run)
      div <= DIV_RESET;
    else
      div <= div + 10'h001;
  end

  // Low bits all ones once per divided period
  assign tick = run && ((div & DIV_MASK[sel]) == DIV_MASK[sel]);

endmodule
`default_nettype wire

//--- core/t16c_wavegen.sv
// One compare channel's waveform generator and pin override.
// Assumes count, compare and mode come from flops on pclk.
`default_nettype none
module t16c_wavegen
  import t16c_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        enabled,
  input  wire logic        tick,
  input  wire logic [2:0]  mode,
  input  wire logic [15:0] count,
  input  wire logic [15:0] cmp,
  input  wire logic        cnt_down,
  input  wire logic        ov_value,
  input  wire logic        override,
  input  wire logic        port_level,
  output logic             pin
);

  logic level;
  logic match;
  logic wave_mode;

  assign match     = tick && (count == cmp);
  assign wave_mode = (mode == WGM_FREQ) || (mode == WGM_ONE_SLOPE) || (mode >= WGM_TWO_TOP);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      level <= 1'b0;
    else if (!enabled)
      level <= ov_value;
    else if (tick)
    begin
      case (mode)
        WGM_FREQ:
          level <= match ? ~level : level;
        WGM_ONE_SLOPE:
          if (count == COUNT_RESET)
            level <= 1'b1;
          else if (match)
            level <= 1'b0;
        WGM_TWO_TOP, WGM_TWO_BOTH, WGM_TWO_BOTTOM:
          level <= match ? cnt_down : level;
        default:
          level <= level;
      endcase
    end
  end

  // Normal and reserved modes never reach the pin
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin <= 1'b0;
    else
      pin <= (override && wave_mode) ? level : port_level;
  end

endmodule
`default_nettype wire

//--- core/t16c_top.sv
// Control register group of a 16-bit three-channel timer, normal mode.
// Assumes an APB master on pclk and port pins fed from the same clock.
`default_nettype none

// Functional notes
// - Clock select divides by 1 to 1024
// - Control A bit 0 enables, resets zero
// - Override drives waveform onto pin in wave modes
// - Auto-lock holds lock until enabled buffers valid
// - Lock stays clear until update, then sets
// - Normal mode produces no waveform at pins
// - Normal and frequency modes: update, overflow at TOP counting up, BOTTOM counting down
// - PWM: period TOP, bottom update, mode overflow
// - Disabled timer: output value bits set levels
// - Split bit makes two 8-bit counters
// - Control-E clear register clears written ones
// - Control-E set register sets written ones
// - Both control-E registers read same status
// - Command: update, restart, hard reset if disabled
// - Command bits always read as zero
// - Lock set blocks buffered register loads
// - Direction bit: zero up, one down, writable
// - Buffer-valid clear register clears written ones
// - Buffer write sets valid, update clears it
// - Valid bits: period bit 0, compares 1-3
module t16c_top
  import t16c_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [2:0]  port_output_level,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic [2:0]       waveform_output,
  output logic             overflow_event,
  output logic             split_mode_select
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [3:0]  ctrl_a;
  logic [6:0]  ctrl_b;
  logic [2:0]  compare_output_value;
  logic        update_lock;
  logic        dir;
  logic [3:0]  buffer_valid;
  logic [15:0] buf_val [4];
  logic [15:0] act_val [4];
  logic [15:0] cnt;

  logic [5:0]  idx;
  logic        hit;
  logic        wr;
  logic        wr_ctrl_a;
  logic        wr_ctrl_b;
  logic        wr_ctrl_c;
  logic        wr_ctrl_d;
  logic        wr_eclr;
  logic        wr_eset;
  logic        wr_fclr;
  logic        wr_fset;
  logic        wr_buf;
  logic [1:0]  cmd;
  logic        cmd_upd;
  logic        cmd_restart;
  logic        cmd_hard;
  logic [31:0] rd_data;

  logic        enable;
  logic [2:0]  clock_divider_select;
  logic [2:0]  waveform_mode;
  logic        auto_lock_update;
  logic [2:0]  compare_output_override;
  logic        tick;
  logic        count_step;
  logic        dual;
  logic [15:0] top_val;
  logic        at_top;
  logic        at_bottom;
  logic        wrap;
  logic        upd_pt;
  logic        ovf_pt;
  logic        update_evt;
  logic        xfer;
  logic [15:0] next_cnt;
  logic [3:0]  next_bv;
  logic        next_lock;
  logic        all_valid;

  assign enable                  = ctrl_a[ENABLE_BIT];
  assign clock_divider_select    = ctrl_a[CLOCK_DIVIDER_SELECT_LSB +: 3];
  assign waveform_mode           = ctrl_b[WGM_LSB +: 3];
  assign auto_lock_update        = ctrl_b[AUTO_LOCK_UPDATE_BIT];
  assign compare_output_override = ctrl_b[OVR_LSB +: 3];

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  assign idx = paddr[7:ADDR_LSB];
  assign wr  = psel && penable && pready && pwrite && hit;

  assign wr_ctrl_a = wr && (idx == IDX_CTRL_A);
  assign wr_ctrl_b = wr && (idx == IDX_CTRL_B);
  assign wr_ctrl_c = wr && (idx == IDX_CTRL_C);
  assign wr_ctrl_d = wr && (idx == IDX_CTRL_D);
  assign wr_eclr   = wr && (idx == IDX_E_CLR);
  assign wr_eset   = wr && (idx == IDX_E_SET);
  assign wr_fclr   = wr && (idx == IDX_F_CLR);
  assign wr_fset   = wr && (idx == IDX_F_SET);
  assign wr_buf    = wr && (idx[5:2] == IDX_BUF_BASE[5:2]);

  // Commands may be issued through either control-E register
  assign cmd         = (wr_eclr || wr_eset) ? pwdata[CMD_LSB +: 2] : CMD_NONE;
  assign cmd_upd     = (cmd == CMD_UPDATE);
  assign cmd_restart = (cmd == CMD_RESTART);
  assign cmd_hard    = (cmd == CMD_HARD_RESET) && !enable;

  always_comb
  begin
    hit     = (paddr[ADDR_LSB-1:0] == 2'h0);
    rd_data = 32'h0000_0000;
    case (idx)
      IDX_CTRL_A:
        rd_data[3:0] = ctrl_a;
      IDX_CTRL_B:
        rd_data[6:0] = ctrl_b;
      IDX_CTRL_C:
        rd_data[2:0] = compare_output_value;
      IDX_CTRL_D:
        rd_data[SPLIT_BIT] = split_mode_select;
      IDX_E_CLR, IDX_E_SET:
      begin
        rd_data[LOCK_BIT] = update_lock;
        rd_data[DIR_BIT]  = dir;
      end
      IDX_F_CLR, IDX_F_SET:
        rd_data[3:0] = buffer_valid;
      IDX_COUNT:
        rd_data[15:0] = cnt;
      default:
      begin
        if (idx[5:2] == IDX_BUF_BASE[5:2])
          rd_data[15:0] = buf_val[idx[1:0]];
        else if (idx[5:2] == IDX_VAL_BASE[5:2])
          rd_data[15:0] = act_val[idx[1:0]];
        else
          hit = 1'b0;
      end
    endcase
  end

  // Zero wait state: data is sampled in the setup cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_data : 32'h0000_0000;
      pslverr <= psel && !penable && !hit;
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_a <= CTRL_A_RESET;
    else if (wr_ctrl_a)
      ctrl_a <= pwdata[3:0];
  end

  // Hard reset only gets through while disabled
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_b               <= CTRL_B_RESET;
      compare_output_value <= CTRL_C_RESET;
      split_mode_select    <= 1'b0;
    end
    else if (cmd_hard)
    begin
      ctrl_b               <= CTRL_B_RESET;
      compare_output_value <= CTRL_C_RESET;
      split_mode_select    <= 1'b0;
    end
    else
    begin
      if (wr_ctrl_b)
        ctrl_b <= pwdata[6:0];
      if (wr_ctrl_c)
        compare_output_value <= pwdata[2:0];
      if (wr_ctrl_d)
        split_mode_select <= pwdata[SPLIT_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Counting
  // ---------------------------------------------------------------
  t16c_prescaler u_prescaler (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (enable),
    .sel     (clock_divider_select),
    .tick    (tick)
  );

  assign count_step = tick && !split_mode_select;
  assign dual       = (waveform_mode >= WGM_TWO_TOP);
  assign top_val    = (waveform_mode == WGM_FREQ) ? act_val[1] : act_val[0];
  assign at_top     = (cnt == top_val);
  assign at_bottom  = (cnt == COUNT_RESET);
  assign wrap       = dir ? at_bottom : at_top;

  always_comb
  begin
    upd_pt = 1'b0;
    ovf_pt = 1'b0;
    case (waveform_mode)
      WGM_NORMAL, WGM_FREQ:
      begin
        upd_pt = wrap;
        ovf_pt = wrap;
      end
      WGM_ONE_SLOPE:
      begin
        upd_pt = at_bottom;
        ovf_pt = at_bottom;
      end
      WGM_TWO_TOP:
      begin
        upd_pt = at_bottom;
        ovf_pt = at_top;
      end
      WGM_TWO_BOTH:
      begin
        upd_pt = at_bottom;
        ovf_pt = at_top || at_bottom;
      end
      WGM_TWO_BOTTOM:
      begin
        upd_pt = at_bottom;
        ovf_pt = at_bottom;
      end
      default:
      begin
        upd_pt = 1'b0;
        ovf_pt = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    if (dual)
      next_cnt = (dir ^ (dir ? at_bottom : at_top)) ? cnt - 16'h0001 : cnt + 16'h0001;
    else if (!dir)
      next_cnt = at_top ? COUNT_RESET : cnt + 16'h0001;
    else
      next_cnt = at_bottom ? top_val : cnt - 16'h0001;
  end

  // Split halves count down and reload from the period bytes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= COUNT_RESET;
    else if (cmd_hard || cmd_restart)
      cnt <= COUNT_RESET;
    else if (tick && split_mode_select)
    begin
      cnt[7:0]  <= (cnt[7:0] == 8'h00) ? act_val[0][7:0] : cnt[7:0] - 8'h01;
      cnt[15:8] <= (cnt[15:8] == 8'h00) ? act_val[0][15:8] : cnt[15:8] - 8'h01;
    end
    else if (count_step)
      cnt <= next_cnt;
  end

  // Turning points of two-slope modes win over software direction writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir <= 1'b0;
    else if (cmd_hard || cmd_restart)
      dir <= 1'b0;
    else if (count_step && dual && !dir && at_top)
      dir <= 1'b1;
    else if (count_step && dual && dir && at_bottom)
      dir <= 1'b0;
    else if (wr_eset && pwdata[DIR_BIT])
      dir <= 1'b1;
    else if (wr_eclr && pwdata[DIR_BIT])
      dir <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      overflow_event <= 1'b0;
    else
      overflow_event <= count_step && ovf_pt;
  end

  // ---------------------------------------------------------------
  // Buffers, valid bits and lock
  // ---------------------------------------------------------------
  assign update_evt = (count_step && upd_pt) || cmd_upd;
  assign xfer       = update_evt && !update_lock;

  always_comb
  begin
    next_bv = buffer_valid;
    if (xfer)
      next_bv = BV_RESET;
    if (wr_fclr)
      next_bv = next_bv & ~pwdata[3:0];
    if (wr_fset)
      next_bv = next_bv | pwdata[3:0];
    if (wr_buf)
      next_bv[idx[1:0]] = 1'b1;
    if (cmd_hard)
      next_bv = BV_RESET;
  end

  assign all_valid = &(next_bv[3:1] | ~compare_output_override);

  // Auto-lock follows the valid bits after every other source except hard reset
  always_comb
  begin
    next_lock = update_lock;
    if (wr_eclr && pwdata[LOCK_BIT])
      next_lock = 1'b0;
    if (wr_eset && pwdata[LOCK_BIT])
      next_lock = 1'b1;
    if (auto_lock_update)
      next_lock = !all_valid;
    if (cmd_hard)
      next_lock = 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      buffer_valid <= BV_RESET;
      update_lock  <= 1'b0;
    end
    else
    begin
      buffer_valid <= next_bv;
      update_lock  <= next_lock;
    end
  end

  // Entry 0 is the period, entries 1 to 3 the compare channels
  for (genvar i = 0; i < 4; i++)
  begin : g_buf
    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        buf_val[i] <= (i == 0) ? PERIOD_RESET : COMPARE_RESET;
        act_val[i] <= (i == 0) ? PERIOD_RESET : COMPARE_RESET;
      end
      else if (cmd_hard)
      begin
        buf_val[i] <= (i == 0) ? PERIOD_RESET : COMPARE_RESET;
        act_val[i] <= (i == 0) ? PERIOD_RESET : COMPARE_RESET;
      end
      else
      begin
        if (wr_buf && (idx[1:0] == 2'(i)))
          buf_val[i] <= pwdata[15:0];
        if (xfer && buffer_valid[i])
          act_val[i] <= buf_val[i];
      end
    end
  end

  // ---------------------------------------------------------------
  // Waveform outputs
  // ---------------------------------------------------------------
  for (genvar ch = 0; ch < 3; ch++)
  begin : g_wave
    t16c_wavegen u_wavegen (
      .pclk       (pclk),
      .presetn    (presetn),
      .enabled    (enable),
      .tick       (count_step),
      .mode       (waveform_mode),
      .count      (cnt),
      .cmp        (act_val[ch+1]),
      .cnt_down   (dir),
      .ov_value   (compare_output_value[ch]),
      .override   (compare_output_override[ch]),
      .port_level (port_output_level[ch]),
      .pin        (waveform_output[ch])
    );
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup_read_e;
    psel && !penable && !pwrite && (idx == IDX_E_CLR || idx == IDX_E_SET);
  endsequence

  sequence s_locked_update;
    update_evt && update_lock && !cmd_hard;
  endsequence

  AST_CMD_READS_ZERO: assert property (s_setup_read_e |=> prdata[3:2] == 2'h0)
    else $error("command bits read nonzero");
  AST_E_STATUS_READ: assert property
    (s_setup_read_e |=> prdata[1:0] == $past({update_lock, dir}))
    else $error("control-E readback differs from status");
  AST_DIV2_ALTERNATES: assert property
    (tick && enable && clock_divider_select == 3'h1 && !wr_ctrl_a |=> !tick)
    else $error("divide by two ticked twice in a row");
  AST_NORMAL_NO_WAVE: assert property
    (waveform_mode == WGM_NORMAL |=> waveform_output == $past(port_output_level))
    else $error("normal mode drove a waveform");
  AST_LOCKED_NO_LOAD: assert property
    (s_locked_update |=> act_val[0] == $past(act_val[0]) && act_val[1] == $past(act_val[1]))
    else $error("locked update loaded a register");
  // A same-cycle buffer write or valid set may legally keep the lock open
  AST_AUTOLOCK_RELOCK: assert property
    (xfer && auto_lock_update && !wr_buf && !wr_fset && compare_output_override != 3'h0
     |=> update_lock)
    else $error("auto-lock did not relock after update");
  AST_BUF_SETS_VALID: assert property (wr_buf |=> buffer_valid[$past(idx[1:0])])
    else $error("buffer write left valid bit clear");
  AST_FCLR_CLEARS: assert property (wr_fclr && pwdata[0] |=> !buffer_valid[0])
    else $error("valid clear write did not clear");
  AST_HARD_IGNORED: assert property
    ((wr_eclr || wr_eset) && pwdata[3:2] == CMD_HARD_RESET && enable
     |=> ctrl_b == $past(ctrl_b))
    else $error("hard reset acted while enabled");
  AST_DUAL_TURN: assert property
    (count_step && dual && !dir && at_top && !cmd_restart && !cmd_hard |=> dir ##1 1'b1)
    else $error("two-slope count did not turn at top");

endmodule
`default_nettype wire

//--- verification/t16c_pins.sv
// Port pin model: the port output register beside the timer and a pin sampler.
// Assumes the bench sets the wanted port level; everything runs on pclk.
`default_nettype none
module t16c_pins
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] want,
  input  wire logic [2:0] pin,
  output logic      [2:0] port_level,
  output logic      [2:0] pin_seen
);
  timeunit 1ns;
  timeprecision 1ns;

  // Port register is a flop, as on the real port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_level <= 3'h0;
    end
    else
    begin
      port_level <= want;
    end
  end

  // Pins are read through a flop, one cycle behind
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_seen <= 3'h0;
    end
    else
    begin
      pin_seen <= pin;
    end
  end
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the timer control block, driven over APB.
// Assumes the pin model on the port side; waits for pready for up to 50 edges.
`default_nettype none
module testbench
  import t16c_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [2:0]  want     = 3'h0;
  logic [2:0]  port_lvl;
  logic [2:0]  pin_seen;
  logic [2:0]  wave;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ovf;
  logic        split;
  logic [31:0] r;
  logic        e;
  int          mismatches = 0;
  int          n_compared = 0;
  int          n;
  int          ov_exp [8] = '{30, 20, 0, 30, 0, 20, 40, 20};

  t16c_top t16c_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .port_output_level(port_lvl),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .waveform_output(wave),
    .overflow_event(ovf), .split_mode_select(split));
  t16c_pins t16c_pins_inst (.pclk(pclk), .presetn(presetn), .want(want), .pin(wave),
    .port_level(port_lvl), .pin_seen(pin_seen));

  initial
  begin
    forever #50 pclk = ~pclk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] x);
    n_compared++;
    if (seen !== x)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, x, seen);
    end
  endtask

  // Request held until pready is seen high at the closing edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Checked at the rising edge itself, before that edge's updates land
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
    begin
      mismatches++;
      end_sim();
    end
    else
    begin
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    xfer(1'b1, {i, 2'b00}, {24'h00_0000, d});
  endtask

  task automatic rd(input logic [5:0] i, input logic [15:0] x);
    xfer(1'b0, {i, 2'b00}, 32'h0000_0000);
    chk($sformatf("reg %h", i), r, {16'h0000, x});
    chk("slverr", {31'h0000_0000, e}, 32'h0000_0000);
  endtask

  // Negedge sampling keeps the count clear of the launching edge
  task automatic wait_ovf(output int c);
    c = 0;
    do
    begin
      @(negedge pclk);
      c++;
    end
    while (ovf !== 1'b1 && c < 9000);
    if (ovf !== 1'b1)
    begin
      mismatches++;
      end_sim();
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd(6'(i), 16'h0000);
    xfer(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", {31'h0000_0000, e}, 32'h0000_0001);
    xfer(1'b0, 8'h01, 32'h0000_0000);
    chk("misaligned", {31'h0000_0000, e}, 32'h0000_0001);
  endtask

  task automatic t_ebits();
    wr(IDX_E_SET, 8'h03);
    rd(IDX_E_CLR, 16'h0003);
    rd(IDX_E_SET, 16'h0003);
    wr(IDX_E_CLR, 8'h01);
    rd(IDX_E_SET, 16'h0002);
    wr(IDX_E_CLR, 8'h06);
    rd(IDX_E_CLR, 16'h0000);
  endtask

  task automatic t_hard();
    wr(IDX_CTRL_B, 8'h03);
    wr(IDX_CTRL_A, 8'h01);
    wr(IDX_E_SET, 8'h0C);
    rd(IDX_CTRL_B, 16'h0003);
    wr(IDX_CTRL_A, 8'h00);
    wr(IDX_E_SET, 8'h0C);
    rd(IDX_CTRL_B, 16'h0000);
    rd(IDX_COUNT, 16'h0000);
  endtask

  task automatic t_valid();
    wr(IDX_BUF_BASE + 6'h02, 8'h09);
    wr(IDX_BUF_BASE, 8'h01);
    rd(IDX_F_CLR, 16'h0005);
    wr(IDX_F_CLR, 8'h04);
    rd(IDX_F_SET, 16'h0001);
    wr(IDX_F_CLR, 8'h01);
    rd(IDX_F_CLR, 16'h0000);
  endtask

  task automatic t_lock();
    wr(IDX_E_SET, 8'h02);
    wr(IDX_BUF_BASE, 8'h03);
    wr(IDX_E_SET, 8'h04);
    rd(IDX_VAL_BASE, 16'hFFFF);
    rd(IDX_F_CLR, 16'h0001);
    wr(IDX_E_CLR, 8'h02);
    wr(IDX_E_SET, 8'h04);
    rd(IDX_VAL_BASE, 16'h0003);
    rd(IDX_F_CLR, 16'h0000);
  endtask

  task automatic t_auto();
    wr(IDX_CTRL_B, 8'h18);
    rd(IDX_E_CLR, 16'h0002);
    wr(IDX_BUF_BASE + 6'h01, 8'h05);
    rd(IDX_E_CLR, 16'h0000);
    wr(IDX_E_SET, 8'h04);
    rd(IDX_VAL_BASE + 6'h01, 16'h0005);
    rd(IDX_E_CLR, 16'h0002);
    wr(IDX_CTRL_B, 8'h00);
    rd(IDX_E_SET, 16'h0002);
    wr(IDX_E_CLR, 8'h02);
  endtask

  task automatic t_pins();
    @(posedge pclk);
    want <= 3'h2;
    wr(IDX_CTRL_C, 8'h05);
    wr(IDX_CTRL_B, 8'h71);
    repeat (3) @(negedge pclk);
    chk("pins", 32'(pin_seen), 32'h0000_0005);
    wr(IDX_CTRL_B, 8'h01);
    repeat (3) @(negedge pclk);
    chk("pins", 32'(pin_seen), 32'h0000_0002);
    wr(IDX_CTRL_B, 8'h70);
    repeat (3) @(negedge pclk);
    chk("pins", 32'(pin_seen), 32'h0000_0002);
    wr(IDX_CTRL_D, 8'h01);
    @(negedge pclk);
    chk("split", 32'(split), 32'h0000_0001);
    wr(IDX_CTRL_D, 8'h00);
  endtask

  // Period 3 gives four ticks between overflows in normal mode
  task automatic t_div();
    wr(IDX_CTRL_B, 8'h00);
    for (int c = 0; c < 8; c++)
    begin
      wr(IDX_CTRL_A, 8'(c * 2));
      wr(IDX_E_SET, 8'h08);
      wr(IDX_CTRL_A, 8'(c * 2 + 1));
      wait_ovf(n);
      wait_ovf(n);
      chk("spacing", 32'(n), 4 * (32'(DIV_MASK[c]) + 1));
    end
  endtask

  // A 120-cycle window holds whole periods of both 4 and 6 ticks
  task automatic t_modes();
    wr(IDX_CTRL_A, 8'h01);
    for (int m = 0; m < 8; m++)
    begin
      wr(IDX_CTRL_B, 8'(m));
      wr(IDX_E_SET, 8'h08);
      repeat (24) @(negedge pclk);
      n = 0;
      repeat (120)
      begin
        @(negedge pclk);
        if (ovf === 1'b1) n++;
      end
      chk($sformatf("overflows %0d", m), 32'(n), 32'(ov_exp[m]));
    end
  endtask

  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ebits();
    t_hard();
    t_valid();
    t_lock();
    t_auto();
    t_pins();
    t_div();
    t_modes();
    end_sim();
  end
endmodule
`default_nettype wire
